// *** hw/ddma_pkg.sv ***
// package: register map, field layout and reset values of the dma slave channel
package ddma_pkg;
  localparam logic [3:0] OFF_ADDR = 4'h0;
  localparam logic [3:0] OFF_PAGE = 4'h2;
  localparam logic [3:0] OFF_COUNT = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h8;
  localparam logic [3:0] OFF_TRIG = 4'h9;
  localparam logic [3:0] OFF_CFG = 4'hb;
  localparam logic [3:0] OFF_MASK = 4'hf;
  localparam int CTRL_DISABLE_BIT = 2;
  localparam int CFG_MODE_HI = 7;
  localparam int CFG_MODE_LO = 6;
  localparam int CFG_ADDR_DIR_BIT = 5;
  localparam int CFG_RELOAD_BIT = 4;
  localparam int CFG_DIR_HI = 3;
  localparam int CFG_DIR_LO = 2;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hfe;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b1;
  localparam logic [15:0] STEP_8BIT = 16'h0001;
  localparam logic [15:0] STEP_16BIT = 16'h0002;
  typedef enum logic [1:0] {
    MODE_DEMAND = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_BLOCK = 2'b10,
    MODE_RSVD = 2'b11
  } ddma_mode_t;
  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_WRITE = 2'b01,
    DIR_READ = 2'b10,
    DIR_RSVD = 2'b11
  } ddma_dir_t;
endpackage : ddma_pkg

// *** hw/ddma_addr_former.sv ***
// address phase former: current address and page onto the ad lines
`timescale 1ns/1ps
`default_nettype none
module ddma_addr_former (
  input wire logic wide_mode,
  input wire logic [15:0] cur_addr,
  input wire logic [7:0] page,
  output logic [31:0] ad_word
);
  import ddma_pkg::*;
  always_comb begin
    ad_word = 32'h0000_0000;
    if (wide_mode) begin
      ad_word[23:17] = page[7:1];
      ad_word[16:1] = cur_addr;
      ad_word[0] = 1'b0;
    end else begin
      ad_word[23:16] = page;
      ad_word[15:0] = cur_addr;
    end
  end
endmodule : ddma_addr_former
`default_nettype wire

// *** hw/ddma_channel.sv ***
// distributed dma slave channel: register window, counters and status
`timescale 1ns/1ps
`default_nettype none
module ddma_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] reg_be,
  output logic [15:0] reg_rdata,
  input wire logic card_dma_request,
  input wire logic card_removed,
  input wire logic mask_clear,
  input wire logic wide_mode,
  input wire logic xfer_done,
  output logic xfer_pending,
  output logic [31:0] ad_word,
  output logic channel_mask,
  output logic controller_disabled,
  output logic [1:0] transfer_mode_select,
  output logic [1:0] transfer_direction
);
  import ddma_pkg::*;

  typedef struct packed {
    logic [1:0] req_sync;
    logic [1:0] rem_sync;
    logic [15:0] base_addr;
    logic [15:0] cur_addr;
    logic [7:0] page;
    logic [15:0] base_count;
    logic [15:0] cur_count;
    logic disable_bit;
    logic [7:0] cfg;
    logic tc_flag;
    logic sw_req;
    logic mask;
    logic pending;
    logic [15:0] rdata;
    logic [31:0] ad;
  } ddma_state_t;

  ddma_state_t s_reg;
  ddma_state_t s_next;
  logic [31:0] ad_comb;
  logic [15:0] step;
  logic [15:0] wdata_m;
  logic req_q;
  logic rem_q;
  logic exhausting;
  logic active;

  ddma_addr_former u_former (
    .wide_mode(wide_mode),
    .cur_addr(s_reg.cur_addr),
    .page(s_reg.page),
    .ad_word(ad_comb)
  );

  assign req_q = s_reg.req_sync[1];
  assign rem_q = s_reg.rem_sync[1];
  assign step = wide_mode ? STEP_16BIT : STEP_8BIT;
  assign exhausting = (s_reg.cur_count <= step);
  // controller disabled blocks all service
  assign active = !s_reg.disable_bit;

  always_comb begin
    s_next = s_reg;
    wdata_m = reg_wdata;
    // logic reads only the second synchroniser stage
    s_next.req_sync = {s_reg.req_sync[0], card_dma_request};
    s_next.rem_sync = {s_reg.rem_sync[0], card_removed};
    if (rem_q) begin
      s_next.mask = 1'b1;
    end else if (mask_clear) begin
      s_next.mask = 1'b0;
    end
    s_next.pending = active && ((req_q && !s_reg.mask) || s_reg.sw_req);
    // transfer completion: step address and count
    if (xfer_done && active) begin
      if (s_reg.cfg[CFG_ADDR_DIR_BIT]) begin
        s_next.cur_addr = s_reg.cur_addr - 16'h0001;
      end else begin
        s_next.cur_addr = s_reg.cur_addr + 16'h0001;
      end
      s_next.cur_count = s_reg.cur_count - step;
      if (exhausting) begin
        s_next.tc_flag = 1'b1;
        s_next.sw_req = 1'b0;
        if (s_reg.cfg[CFG_RELOAD_BIT]) begin
          s_next.cur_addr = s_reg.base_addr;
          s_next.cur_count = s_reg.base_count;
        end
      end
    end
    // register reads; terminal flag clears on read unless set this cycle
    if (reg_rd) begin
      if (reg_addr == OFF_ADDR) begin
        s_next.rdata = s_reg.cur_addr;
      end else if (reg_addr == OFF_PAGE) begin
        s_next.rdata = {8'h00, s_reg.page};
      end else if (reg_addr == OFF_COUNT) begin
        s_next.rdata = s_reg.cur_count;
      end else if (reg_addr == OFF_CTRL) begin
        s_next.rdata = {8'h00, {4{req_q}}, {4{s_reg.tc_flag}}};
        if (!(xfer_done && active && exhausting)) begin
          s_next.tc_flag = 1'b0;
        end
      end else if (reg_addr == OFF_CFG) begin
        s_next.rdata = {8'h00, s_reg.cfg & CFG_WRITE_MASK};
      end else if (reg_addr == OFF_MASK) begin
        s_next.rdata = {15'h0000, s_reg.mask};
      end else begin
        s_next.rdata = 16'h0000;
      end
    end
    // register writes win over the transfer update
    if (reg_wr) begin
      if (reg_addr == OFF_ADDR) begin
        if (reg_be[0]) begin
          s_next.base_addr[7:0] = wdata_m[7:0];
          s_next.cur_addr[7:0] = wdata_m[7:0];
        end
        if (reg_be[1]) begin
          s_next.base_addr[15:8] = wdata_m[15:8];
          s_next.cur_addr[15:8] = wdata_m[15:8];
        end
      end else if (reg_addr == OFF_PAGE) begin
        if (reg_be[0]) begin
          s_next.page = wdata_m[7:0];
        end
      end else if (reg_addr == OFF_COUNT) begin
        if (reg_be[0]) begin
          s_next.base_count[7:0] = wdata_m[7:0];
          s_next.cur_count[7:0] = wdata_m[7:0];
        end
        if (reg_be[1]) begin
          s_next.base_count[15:8] = wdata_m[15:8];
          s_next.cur_count[15:8] = wdata_m[15:8];
        end
      end else if (reg_addr == OFF_CTRL) begin
        if (reg_be[0]) begin
          s_next.disable_bit = wdata_m[CTRL_DISABLE_BIT];
        end
        // byte at 09h rides the upper lane of the 08h word
        if (reg_be[1]) begin
          s_next.sw_req = 1'b1;
        end
      end else if (reg_addr == OFF_TRIG) begin
        if (reg_be[0]) begin
          s_next.sw_req = 1'b1;
        end
      end else if (reg_addr == OFF_CFG) begin
        if (reg_be[0]) begin
          s_next.cfg = wdata_m[7:0] & CFG_WRITE_MASK;
        end
      end
    end
    s_next.ad = ad_comb;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.base_addr <= ADDR_RESET;
      s_reg.cur_addr <= ADDR_RESET;
      s_reg.page <= PAGE_RESET;
      s_reg.base_count <= COUNT_RESET;
      s_reg.cur_count <= COUNT_RESET;
      s_reg.cfg <= CFG_RESET;
      s_reg.mask <= MASK_RESET;
      s_reg.tc_flag <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign xfer_pending = s_reg.pending;
  assign ad_word = s_reg.ad;
  assign channel_mask = s_reg.mask;
  assign controller_disabled = s_reg.disable_bit;
  assign transfer_mode_select = s_reg.cfg[CFG_MODE_HI:CFG_MODE_LO];
  assign transfer_direction = s_reg.cfg[CFG_DIR_HI:CFG_DIR_LO];
endmodule : ddma_channel
`default_nettype wire

// *** sim/ddma_props.sv ***
// port assertions for the dma slave channel
`timescale 1ns/1ps
`default_nettype none
module ddma_props
  import ddma_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_rdata,
  input wire logic card_removed,
  input wire logic mask_clear,
  input wire logic wide_mode,
  input wire logic xfer_pending,
  input wire logic [31:0] ad_word,
  input wire logic channel_mask,
  input wire logic controller_disabled,
  input wire logic [1:0] transfer_mode_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  cfg_low_zero_a: assert property (reg_rd && reg_addr == OFF_CFG |=> !reg_rdata[0])
    else $error("mode bit 0 reads one");
  ctrl_write_a: assert property (reg_wr && reg_addr == OFF_CTRL && reg_be[0]
    |=> controller_disabled == $past(reg_wdata[CTRL_DISABLE_BIT])) else $error("disable bit lost");
  mode_write_a: assert property (reg_wr && reg_addr == OFF_CFG && reg_be[0]
    |=> transfer_mode_select == $past(reg_wdata[7:6])) else $error("mode field lost");
  mask_on_removal_a: assert property (card_removed |-> ##[1:4] channel_mask)
    else $error("mask not set on removal");
  disabled_idle_a: assert property (controller_disabled && $past(controller_disabled) |-> !xfer_pending)
    else $error("request while disabled");
  wide_ad0_a: assert property ($past(wide_mode) |-> !ad_word[0])
    else $error("ad0 high in wide mode");
  mask_clear_a: assert property ($fell(channel_mask) |-> $past(mask_clear))
    else $error("mask dropped unasked");
  reset_state_a: assert property (disable iff (1'h0) rst |=> channel_mask && reg_rdata == 16'h0000)
    else $error("reset state wrong");
endmodule : ddma_props
`default_nettype wire

// *** sim/ddma_card_model.sv ***
// far side model: card request level and transfer-done pulses
`timescale 1ns/1ps
`default_nettype none
module ddma_card_model (
  input wire logic clk,
  output logic card_dma_request,
  output logic xfer_done
);
  initial card_dma_request = 1'h0;
  initial xfer_done = 1'h0;
  task automatic raise(input logic v);
    @(posedge clk);
    card_dma_request <= v;
  endtask : raise
  // idle cycle between pulses, as a slow far side
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk);
      xfer_done <= 1'h1;
      @(posedge clk);
      xfer_done <= 1'h0;
    end
  endtask : burst
endmodule : ddma_card_model
`default_nettype wire

// *** sim/ddma_channel_tb.sv ***
// self-checking bench for the dma slave channel
`timescale 1ns/1ps
`default_nettype none
module ddma_channel_tb;
  import ddma_pkg::*;
  logic clk, rst, reg_wr, reg_rd, card_removed, mask_clear, wide_mode;
  logic card_dma_request, xfer_done, xfer_pending, channel_mask, controller_disabled;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [1:0] reg_be, transfer_mode_select, transfer_direction;
  logic [31:0] ad_word;
  logic [3:0] offs [5] = '{OFF_ADDR, OFF_PAGE, OFF_COUNT, OFF_CTRL, OFF_CFG};
  int bad_count, total_checks;
  ddma_channel ddma_channel_inst (.*);
  ddma_card_model ddma_card_model_inst (.*);
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v, input logic [1:0] b);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_be <= b;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    // data launched at the sampling edge stands until the next read
    @(posedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    rst = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    card_removed = 1'h0;
    mask_clear = 1'h0;
    wide_mode = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_be = 2'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    chk(channel_mask, 1'h1);
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, 16'h0000);
    end
    mask_clear <= 1'h1;
    @(posedge clk);
    mask_clear <= 1'h0;
    wr(OFF_ADDR, 16'h1234, 2'h3);
    wr(OFF_PAGE, 16'h005b, 2'h1);
    wr(OFF_COUNT, 16'h0003, 2'h3);
    rd(OFF_ADDR, d);
    chk(d, 16'h1234);
    chk(32'(ad_word[23:0]), 32'h005b1234);
    ddma_card_model_inst.burst(2);
    rd(OFF_COUNT, d);
    chk(d, 16'h0001);
    ddma_card_model_inst.burst(1);
    rd(OFF_CTRL, d);
    chk(32'(d[3:0]), 32'h0000000f);
    rd(OFF_CTRL, d);
    chk(32'(d[3:0]), 32'h00000000);
    rd(OFF_ADDR, d);
    chk(d, 16'h1237);
    wide_mode <= 1'h1;
    wr(OFF_COUNT, 16'h0004, 2'h3);
    ddma_card_model_inst.burst(1);
    rd(OFF_COUNT, d);
    chk(d, 16'h0002);
    chk(32'(ad_word[23:0]), 32'h005a2470);
    wr(OFF_CFG, 16'h0010, 2'h1);
    ddma_card_model_inst.burst(1);
    rd(OFF_COUNT, d);
    chk(d, 16'h0004);
    rd(OFF_ADDR, d);
    chk(d, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CFG, {8'h00, i[1:0], 2'h0, i[1:0], 2'h0}, 2'h1);
      @(posedge clk);
      chk(transfer_mode_select, i[1:0]);
      chk(transfer_direction, i[1:0]);
    end
    wr(OFF_CFG, 16'h0080, 2'h1);
    card_removed <= 1'h1;
    repeat (4) @(posedge clk);
    card_removed <= 1'h0;
    ddma_card_model_inst.raise(1'h1);
    repeat (4) @(posedge clk);
    chk(xfer_pending, 1'h0);
    rd(OFF_CTRL, d);
    chk(32'(d[7:4]), 32'h0000000f);
    mask_clear <= 1'h1;
    @(posedge clk);
    mask_clear <= 1'h0;
    repeat (2) @(posedge clk);
    chk(xfer_pending, 1'h1);
    ddma_card_model_inst.raise(1'h0);
    repeat (4) @(posedge clk);
    rd(OFF_CTRL, d);
    chk(32'(d[7:4]), 32'h00000000);
    wr(OFF_TRIG, 16'h0000, 2'h1);
    repeat (2) @(posedge clk);
    chk(xfer_pending, 1'h1);
    wr(OFF_CTRL, 16'h00ff, 2'h1);
    repeat (2) @(posedge clk);
    chk(xfer_pending, 1'h0);
    chk(controller_disabled, 1'h1);
    ddma_card_model_inst.burst(1);
    rd(OFF_COUNT, d);
    chk(d, 16'h0004);
    wr(OFF_CTRL, 16'h0000, 2'h1);
    wr(OFF_CFG, 16'h00ff, 2'h1);
    rd(OFF_CFG, d);
    chk(d, 16'h00fe);
    ddma_card_model_inst.burst(1);
    rd(OFF_ADDR, d);
    chk(d, 16'h1233);
    rd(OFF_COUNT, d);
    chk(d, 16'h0002);
    wr(OFF_MASK, 16'h0001, 2'h1);
    rd(OFF_MASK, d);
    chk(d, 16'h0000);
    rd(4'h6, d);
    chk(d, 16'h0000);
    // second reset in mid-run
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(channel_mask, 1'h1);
    chk(controller_disabled, 1'h0);
    chk(transfer_mode_select, 2'h0);
    rd(OFF_COUNT, d);
    chk(d, 16'h0000);
    rd(OFF_PAGE, d);
    chk(d, 16'h0000);
    // upper lane of the 08h word is the 09h trigger byte
    wr(OFF_CTRL, 16'h0004, 2'h2);
    repeat (2) @(posedge clk);
    chk(xfer_pending, 1'h1);
    chk(controller_disabled, 1'h0);
    results();
  end
  initial begin
    #20000;
    bad_count++;
    results();
  end
endmodule : ddma_channel_tb
bind ddma_channel ddma_props ddma_props_inst (.*);
`default_nettype wire
